// ==== pkg/mr0_pkg.sv ====
// Shared constants and types for the mode register zero link.
package mr0_pkg;
  // ----------------------------------------------------------------
  // Command encodings and field layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NOP   = 2'b00,
    CMD_MRS   = 2'b01,
    CMD_READ  = 2'b10,
    CMD_WRITE = 2'b11
  } cmd_e;

  localparam int MR_W        = 19;
  localparam int COL_W       = 10;
  localparam int BL_LSB      = 0;
  localparam int BT_BIT      = 3;
  localparam int CL_LSB      = 4;
  localparam int DLLRST_BIT  = 8;
  localparam int WR_LSB      = 9;
  localparam int PPD_BIT     = 12;
  localparam int OTF_ADDR    = 12;
  localparam logic [MR_W-1:0] MR_RESET = 19'h00000;
  localparam logic [MR_W-1:0] MR_RSVD  = 19'h4e080;

  localparam logic [1:0] BL_FIX8 = 2'b00;
  localparam logic [1:0] BL_OTF  = 2'b01;
  localparam logic [1:0] BL_BC4  = 2'b10;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int DLLK_CYC    = 512;
  localparam int MOD_CYC     = 12;
  localparam int BEATS       = 8;
  localparam int LINK_DIV    = 4;
endpackage : mr0_pkg

// ==== pkg/mr0_if.sv ====
// Link between controller and device: clock, command, address, data.
`timescale 1ns/1ps
interface mr0_if;
  logic                       ck;
  mr0_pkg::cmd_e              cmd;
  logic [mr0_pkg::MR_W-1:0]   addr;
  logic [7:0]                 dq_ctl;
  logic                       dq_ctl_oe;
  logic [7:0]                 dq_dev;
  logic                       dq_dev_oe;
  logic                       dqs_dev;
  logic                       dqs_dev_oe;
  logic                       reset_n;

  modport ctl (output ck, cmd, addr, dq_ctl, dq_ctl_oe, reset_n,
               input dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe);
  modport dev (input ck, cmd, addr, dq_ctl, dq_ctl_oe, reset_n,
               output dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe);
endinterface : mr0_if

// ==== core/mr0_device.sv ====
// Device end: mode register zero, decode and burst ordering.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Behaviour
// - MR0 bits 1:0 choose burst length
// - on-the-fly: A12 low BC4, high BL8
// - burst wraps inside aligned column block
// - burst length applies to reads and writes
// - controller writes reserved bits as zero
// - bit 3 picks sequential or interleaved
// - sequential read rotates within nibbles
// - interleaved read beat is start XOR k
// - BC4 read tri-states last four beats
// - writes ignore low column bits
// - BC4 and BL8 start same time
// - bit 8 starts DLL reset, self-clears
// - controller waits 512 clocks before read
// - bits 11:9 select write recovery
// - testbench rounds write recovery up
// - bit 12 keeps DLL in power-down
// - bits 6:4 set CAS latency 5-11
// - first read data at n plus m
// - controller idles for tMOD after MRS
// - register bits other than bit 8 held until reprogrammed or reset
module mr0_device (
  input  wire logic                ref_clk_in,     // System clock.
  input  wire logic                sys_rst_in,     // Synchronous reset.
  mr0_if.dev                       link,           // Link to controller.
  output logic [mr0_pkg::MR_W-1:0] mode_out,       // Stored mode register.
  output logic [3:0]               cas_lat_out,    // CAS latency in clocks.
  output logic [3:0]               wr_rec_out,     // Write recovery in clocks.
  output logic                     dll_run_pd_out, // DLL runs in power-down.
  output logic                     dll_rst_out,    // DLL reset pulse.
  output logic [2:0]               col_out,        // Column of current beat.
  output logic                     col_valid_out,  // Column valid.
  output logic                     col_wr_out,     // Beat belongs to a write.
  output logic [7:0]               wdata_out       // Captured write data.
);
  import mr0_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ck_r;
  logic       rstn_s1_r;
  logic       rstn_r;
  always_ff @(posedge ref_clk_in) begin
    ck_r      <= sys_rst_in ? 3'h0 : {ck_r[1:0], link.ck};
    rstn_s1_r <= sys_rst_in ? 1'b0 : link.reset_n;
    rstn_r    <= sys_rst_in ? 1'b0 : rstn_s1_r;
  end
  wire ck_rise = ck_r[1] & ~ck_r[2];
  wire dev_rst = sys_rst_in | ~rstn_r;

  // Command and address are stable across a link edge, so they are
  // sampled once on the detected rise after a two-stage delay.
  cmd_e            cmd_s1_r, cmd_r;
  logic [MR_W-1:0] addr_s1_r, addr_r;
  logic [7:0]      dq_s1_r, dq_r;
  always_ff @(posedge ref_clk_in) begin
    cmd_s1_r  <= link.cmd;
    cmd_r     <= cmd_s1_r;
    addr_s1_r <= link.addr;
    addr_r    <= addr_s1_r;
    dq_s1_r   <= link.dq_ctl;
    dq_r      <= dq_s1_r;
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  logic [MR_W-1:0] mr_r;
  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      mr_r <= MR_RESET;
    end else if (ck_rise && cmd_r == CMD_MRS) begin
      mr_r <= addr_r & ~MR_RSVD;
    end else if (mr_r[DLLRST_BIT]) begin
      mr_r[DLLRST_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    dll_rst_out <= dev_rst ? 1'b0 : (mr_r[DLLRST_BIT] & ~dll_rst_out);
  end

  function automatic logic [3:0] cl_decode(input logic [2:0] f);
    cl_decode = (f == 3'h0) ? 4'h5 : ({1'b0, f} + 4'h4);
  endfunction : cl_decode

  function automatic logic [3:0] wr_decode(input logic [2:0] f);
    unique case (f)
      3'h1: wr_decode = 4'h5;
      3'h2: wr_decode = 4'h6;
      3'h3: wr_decode = 4'h7;
      3'h4: wr_decode = 4'h8;
      3'h5: wr_decode = 4'ha;
      3'h6: wr_decode = 4'hc;
      3'h0, 3'h7: wr_decode = 4'he;
    endcase
  endfunction : wr_decode

  always_ff @(posedge ref_clk_in) begin
    mode_out       <= mr_r;
    cas_lat_out    <= cl_decode(mr_r[CL_LSB +: 3]);
    wr_rec_out     <= wr_decode(mr_r[WR_LSB +: 3]);
    dll_run_pd_out <= mr_r[PPD_BIT];
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT  = 2'b01,
    ST_BEAT = 2'b10
  } st_e;
  st_e        st_r;
  logic [3:0] lat_r;
  logic [2:0] beat_r;
  logic [2:0] start_r;
  logic       chop_r;
  logic       wr_r;
  logic       ilv_r;

  function automatic logic [2:0] burst_col(input logic [2:0] s, input logic [2:0] k,
                                           input logic ilv, input logic wr, input logic chop);
    logic [2:0] c;
    c = 3'h0;
    if (wr) begin
      c = chop ? {s[2], k[1:0]} : k;
    end else if (ilv) begin
      c = s ^ k;
    end else begin
      c = {s[2] ^ k[2], 2'(s[1:0] + k[1:0])};
    end
    burst_col = c;
  endfunction : burst_col

  wire [1:0] bl = mr_r[BL_LSB +: 2];
  wire chop_now = (bl == BL_BC4) || (bl == BL_OTF && !addr_r[OTF_ADDR]);

  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      st_r    <= ST_IDLE;
      lat_r   <= 4'h0;
      beat_r  <= 3'h0;
      start_r <= 3'h0;
      chop_r  <= 1'b0;
      wr_r    <= 1'b0;
      ilv_r   <= 1'b0;
    end else if (ck_rise) begin
      unique case (st_r)
        ST_IDLE: begin
          if (cmd_r == CMD_READ || cmd_r == CMD_WRITE) begin
            st_r    <= ST_LAT;
            wr_r    <= (cmd_r == CMD_WRITE);
            chop_r  <= chop_now;
            ilv_r   <= mr_r[BT_BIT];
            start_r <= addr_r[2:0];
            lat_r   <= (cmd_r == CMD_WRITE) ? 4'h1 : cl_decode(mr_r[CL_LSB +: 3]) - 4'h1;
            beat_r  <= 3'h0;
          end
        end
        ST_LAT: begin
          if (lat_r <= 4'h1) begin
            st_r <= ST_BEAT;
          end
          lat_r <= lat_r - 4'h1;
        end
        ST_BEAT: begin
          beat_r <= beat_r + 3'h1;
          if (beat_r == 3'(BEATS - 1)) begin
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // One beat falls in each link period; beat_r advances on each detected rise.
  wire in_beat  = (st_r == ST_BEAT);
  wire live     = in_beat && !(chop_r && beat_r[2]);
  always_ff @(posedge ref_clk_in) begin
    col_out         <= burst_col(start_r, beat_r, ilv_r, wr_r, chop_r);
    col_valid_out   <= dev_rst ? 1'b0 : live;
    col_wr_out      <= wr_r;
    wdata_out       <= dq_r;
    link.dq_dev     <= {5'h00, burst_col(start_r, beat_r, ilv_r, wr_r, chop_r)};
    link.dq_dev_oe  <= dev_rst ? 1'b0 : (live && !wr_r);
    link.dqs_dev    <= beat_r[0];
    link.dqs_dev_oe <= dev_rst ? 1'b0 : (live && !wr_r);
  end
endmodule : mr0_device

// ==== core/mr0_controller.sv ====
// Controller end: issues mode set, read and write with required waits.
`timescale 1ns/1ps
module mr0_controller (
  input  wire logic                ref_clk_in, // System clock.
  input  wire logic                sys_rst_in, // Synchronous reset.
  mr0_if.ctl                       link,       // Link to device.
  input  wire logic [1:0]          req_in,     // Request: 1 MRS, 2 read, 3 write.
  input  wire logic [mr0_pkg::MR_W-1:0] addr_in, // Mode value or column address.
  input  wire logic [7:0]          wdata_in,   // Write data.
  input  wire logic                mem_rst_in, // Drive device reset.
  output logic                     busy_out,   // Request in progress or waiting.
  output logic [7:0]               rdata_out,  // Last read data.
  output logic                     rvalid_out  // Read data pulse.
);
  import mr0_pkg::*;

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  logic [1:0] div_r;
  always_ff @(posedge ref_clk_in) begin
    div_r   <= sys_rst_in ? 2'h0 : div_r + 2'h1;
    link.ck <= sys_rst_in ? 1'b0 : (div_r >= 2'(LINK_DIV / 2));
  end
  // Changes launch just after the falling link edge.
  wire fall = (div_r == 2'(LINK_DIV / 2 - 1));

  // ----------------------------------------------------------------
  // Command issue and waits
  // ----------------------------------------------------------------
  logic [9:0] mod_r;
  logic [9:0] dllk_r;
  logic [1:0] pend_r;
  logic [MR_W-1:0] paddr_r;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pend_r       <= 2'h0;
      paddr_r      <= '0;
      link.cmd     <= CMD_NOP;
      link.addr    <= '0;
      link.dq_ctl  <= 8'h00;
      link.dq_ctl_oe <= 1'b0;
      link.reset_n <= 1'b0;
      mod_r        <= 10'h000;
      dllk_r       <= 10'h000;
    end else begin
      link.reset_n <= ~mem_rst_in;
      if (req_in != 2'h0 && pend_r == 2'h0) begin
        pend_r  <= req_in;
        paddr_r <= addr_in;
        link.dq_ctl <= wdata_in;
      end
      if (fall) begin
        link.cmd <= CMD_NOP;
        if (mod_r != 10'h000) mod_r <= mod_r - 10'h001;
        if (dllk_r != 10'h000) dllk_r <= dllk_r - 10'h001;
        if (pend_r != 2'h0 && mod_r == 10'h000 &&
            !(pend_r == 2'h2 && dllk_r != 10'h000)) begin
          link.cmd <= cmd_e'(pend_r);
          link.addr <= (pend_r == 2'h1) ? (paddr_r & ~MR_RSVD) : paddr_r;
          link.dq_ctl_oe <= (pend_r == 2'h3);
          pend_r <= 2'h0;
          if (pend_r == 2'h1) begin
            mod_r <= 10'(MOD_CYC);
            if (paddr_r[DLLRST_BIT]) dllk_r <= 10'(DLLK_CYC);
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    busy_out   <= sys_rst_in ? 1'b0 : (pend_r != 2'h0 || mod_r != 10'h000);
    rvalid_out <= sys_rst_in ? 1'b0 : (link.dq_dev_oe && fall);
    rdata_out  <= link.dq_dev;
  end
endmodule : mr0_controller

// ==== sim/mr0_link_monitor.sv ====
// Checker for the link between the controller and device ends.
`timescale 1ns/1ps
module mr0_link_monitor (
  input  wire logic                ref_clk_in, // System clock.
  input  wire logic                sys_rst_in, // Synchronous reset.
  input  wire logic                ck,         // Link clock.
  input  mr0_pkg::cmd_e            cmd,        // Link command.
  input  wire logic [mr0_pkg::MR_W-1:0] addr,  // Link address.
  input  wire logic                dq_ctl_oe,  // Controller data enable.
  input  wire logic                dq_dev_oe,  // Device data enable.
  input  wire logic                dqs_dev_oe  // Device strobe enable.
);
  import mr0_pkg::*;
  logic          ck_d;
  mr0_pkg::cmd_e cmd_d;
  logic [3:0]    mod_n;
  logic [9:0]    dll_n;
  logic [5:0]    oe_n;
  wire           rise = ck & ~ck_d;
  wire           mrs_on = (cmd == CMD_MRS) && (cmd_d != CMD_MRS);
  always_ff @(posedge ref_clk_in) begin
    ck_d  <= ck;
    cmd_d <= cmd;
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) mod_n <= 4'hf;
    else if (mrs_on) mod_n <= 4'h0;
    else if (rise && mod_n != 4'hf) mod_n <= mod_n + 4'h1;
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) dll_n <= 10'h3ff;
    else if (mrs_on && addr[DLLRST_BIT]) dll_n <= 10'h000;
    else if (rise && dll_n != 10'h3ff) dll_n <= dll_n + 10'h001;
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !dq_dev_oe) oe_n <= 6'h00;
    else oe_n <= oe_n + 6'h01;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rsvd_zero; cmd == CMD_MRS |-> (addr & MR_RSVD) == '0; endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved mode bit sent");
  property p_mod_wait; cmd != cmd_d && cmd inside {CMD_READ, CMD_WRITE} |-> mod_n >= MOD_CYC;
  endproperty
  a_mod_wait: assert property (p_mod_wait) else $error("access too soon after mode set");
  property p_dllk_wait; cmd != cmd_d && cmd == CMD_READ |-> dll_n >= DLLK_CYC; endproperty
  a_dllk_wait: assert property (p_dllk_wait) else $error("read too soon after reset");
  property p_cmd_low; !$stable(cmd) |-> !ck; endproperty
  a_cmd_low: assert property (p_cmd_low) else $error("command moved while clock high");
  property p_ck_shape; $rose(ck) |=> ck ##1 !ck; endproperty
  a_ck_shape: assert property (p_ck_shape) else $error("link clock high time wrong");
  property p_strobe_oe; dq_dev_oe == dqs_dev_oe; endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("data and strobe enables differ");
  property p_no_fight; !(dq_dev_oe && dq_ctl_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_burst_len; $fell(dq_dev_oe) |-> oe_n == 6'd16 || oe_n == 6'd32; endproperty
  a_burst_len: assert property (p_burst_len) else $error("read burst length wrong");
  c_dll: cover property (mrs_on && addr[DLLRST_BIT]);
  c_bc4: cover property ($fell(dq_dev_oe) && oe_n == 6'd16);
  c_bl8: cover property ($fell(dq_dev_oe) && oe_n == 6'd32);
  c_wr: cover property (dq_ctl_oe);
endmodule : mr0_link_monitor

// ==== sim/testbench.sv ====
// Self-checking bench for the controller and device ends.
`timescale 1ns/1ps
module testbench;
  import mr0_pkg::*;
  logic            ref_clk_in = 1'b0;
  logic            sys_rst_in = 1'b1;
  logic            mem_rst_in = 1'b0;
  logic [1:0]      req_in     = 2'd0;
  logic [MR_W-1:0] addr_in    = '0;
  logic [7:0]      wdata_in   = 8'h00;
  logic [MR_W-1:0] mode_out;
  logic [3:0]      cas_lat_out, wr_rec_out;
  logic            dll_run_pd_out, dll_rst_out, col_valid_out, col_wr_out, busy_out, rvalid_out;
  logic [2:0]      col_out, pc;
  logic [7:0]      wdata_out, rdata_out;
  logic [2:0]      qc[$];
  logic [2:0]      qd[$];
  logic            qw[$];
  logic            pv = 1'b0;
  logic            pw;
  logic            ckd = 1'b0;
  logic            poe = 1'b0;
  int              n_rst, cyc, n_mismatch, checks, rd_t, lat_seen;
  mr0_if link();
  mr0_controller i_mr0_controller (.ref_clk_in, .sys_rst_in, .link(link.ctl), .req_in, .addr_in,
    .wdata_in, .mem_rst_in, .busy_out, .rdata_out, .rvalid_out);
  mr0_device i_mr0_device (.ref_clk_in, .sys_rst_in, .link(link.dev), .mode_out, .cas_lat_out,
    .wr_rec_out, .dll_run_pd_out, .dll_rst_out, .col_out, .col_valid_out, .col_wr_out, .wdata_out);
  mr0_link_monitor i_mr0_link_monitor (.ref_clk_in, .sys_rst_in, .ck(link.ck), .cmd(link.cmd),
    .addr(link.addr), .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe),
    .dqs_dev_oe(link.dqs_dev_oe));
  initial forever #12.5 ref_clk_in = ~ref_clk_in;
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(string what, logic [MR_W-1:0] exp, logic [MR_W-1:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // Each new beat shows as a change of column while valid.
  always @(posedge ref_clk_in) begin
    if (col_valid_out === 1'b1 && (!pv || col_out != pc || col_wr_out != pw)) begin
      qc.push_back(col_out);
      qw.push_back(col_wr_out);
    end
    pv <= col_valid_out;
    pc <= col_out;
    pw <= col_wr_out;
    if (rvalid_out === 1'b1) qd.push_back(rdata_out[2:0]);
    // Read latency runs from the link rise that carries the read to the first driven beat.
    if (link.ck === 1'b1 && !ckd && link.cmd == CMD_READ) rd_t = cyc;
    if (link.dq_dev_oe === 1'b1 && !poe) lat_seen = cyc - rd_t;
    ckd <= link.ck;
    poe <= link.dq_dev_oe;
    if (dll_rst_out === 1'b1) n_rst++;
    cyc++;
    if (cyc > 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 4000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("idle", 1'b0, busy_out);
  endtask : wait_idle
  task automatic req(logic [1:0] k, logic [MR_W-1:0] a, logic [7:0] d);
    wait_idle();
    @(posedge ref_clk_in);
    req_in   <= k;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    req_in <= 2'd0;
    repeat (3) @(negedge ref_clk_in);
    wait_idle();
    repeat (120) @(negedge ref_clk_in);
  endtask : req
  function automatic logic [2:0] rcol(logic [2:0] s, int k, logic ilv);
    return ilv ? s ^ 3'(k) : {s[2] ^ k[2], s[1:0] + 2'(k)};
  endfunction : rcol
  // Write recovery in clocks from times in ps, rounded up to a whole clock.
  function automatic int wr_cycles(int twr_ps, int tck_ps);
    return (twr_ps + tck_ps - 1) / tck_ps;
  endfunction : wr_cycles
  function automatic logic [2:0] wr_field(int c);
    return (c == 14) ? 3'h0 : ((c <= 8) ? 3'(c - 4) : 3'(c / 2));
  endfunction : wr_field
  task automatic burst(logic wr, logic [2:0] s, logic ilv, logic chop, int cl);
    chk("beats", chop ? 4 : 8, qc.size());
    for (int k = 0; k < qc.size() && k < 8; k++) begin
      chk("col", wr ? (chop ? {s[2], 2'(k)} : 3'(k)) : rcol(s, k, ilv), qc[k]);
      chk("dir", wr, qw[k]);
    end
    if (!wr) begin
      chk("rbeats", chop ? 4 : 8, qd.size());
      for (int k = 0; k < qd.size() && k < 8; k++) begin
        chk("rdata", rcol(s, k, ilv), qd[k]);
      end
      chk("latency", LINK_DIV * cl, lat_seen);
    end
    qc.delete();
    qw.delete();
    qd.delete();
  endtask : burst
  initial begin
    logic [MR_W-1:0] m, e;
    logic [7:0]      d;
    logic [2:0]      s, f;
    logic            chop;
    int              bl, cl, c;
    int              tck_ps[7] = '{3000, 2500, 2143, 1875, 1500, 1250, 1072};
    void'($urandom(32'h82f3));
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      m = 19'($urandom);
      bl = i % 3;
      m[1:0] = 2'(bl);
      m[DLLRST_BIT] = (i % 5 == 0);
      c = wr_cycles(15000, tck_ps[i % 7]);
      m[WR_LSB +: 3] = wr_field(c);
      n_rst = 0;
      req(2'd1, m, 8'h00);
      e = m & ~MR_RSVD;
      e[DLLRST_BIT] = 1'b0;
      f = m[11:9];
      chk("mode", e, mode_out);
      cl = (m[6:4] == 3'd0) ? 5 : m[6:4] + 4;
      chk("cl", cl, cas_lat_out);
      chk("wr round", c, wr_rec_out);
      chk("wrec", f == 3'd0 ? 14 : (f < 3'd5 ? f + 4 : f * 2), wr_rec_out);
      chk("ppd", m[PPD_BIT], dll_run_pd_out);
      chk("dllrst", m[DLLRST_BIT], n_rst);
      s = (i < 8) ? 3'(i) : 3'($urandom);
      e = '0;
      e[COL_W-1:0] = 10'($urandom);
      e[2:0] = s;
      e[OTF_ADDR] = 1'($urandom);
      chop = (bl == 2) || (bl == 1 && !e[OTF_ADDR]);
      req(2'd2, e, 8'h00);
      burst(1'b0, s, m[BT_BIT], chop, cl);
      d = 8'($urandom);
      req(2'd3, e, d);
      burst(1'b1, s, m[BT_BIT], chop, cl);
      chk("wdata", d, wdata_out);
    end
    @(posedge ref_clk_in);
    mem_rst_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    mem_rst_in <= 1'b0;
    repeat (10) @(negedge ref_clk_in);
    chk("mode cleared", MR_RESET, mode_out);
    report_and_stop();
  end
endmodule : testbench
